// [rtl/trace_trigger_pkg.sv]
/*
  Shared constants for the trace trigger and capture block: widths, trigger
  mode codes, the run-state type and the fixed entry adjustments.
  Assumes a 16-bit core address bus and an 8-bit core data bus.
*/
package trace_trigger_pkg;

    // Bus and buffer geometry.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int BUF_DEPTH = 8;
    localparam int MODE_W = 4;
    localparam int COUNT_W = 4;

    // Trigger mode codes.
    localparam logic [MODE_W-1:0] MODE_A_ONLY = 4'h0; // RULE25 RULE27
    localparam logic [MODE_W-1:0] MODE_A_OR_B = 4'h1; // RULE25 RULE27
    localparam logic [MODE_W-1:0] MODE_A_THEN_B = 4'h2;
    localparam logic [MODE_W-1:0] MODE_EVENT_B = 4'h3;
    localparam logic [MODE_W-1:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [MODE_W-1:0] MODE_A_AND_B = 4'h5;
    localparam logic [MODE_W-1:0] MODE_A_AND_NOT_B = 4'h6;
    localparam logic [MODE_W-1:0] MODE_INSIDE = 4'h7;
    localparam logic [MODE_W-1:0] MODE_OUTSIDE = 4'h8; // RULE27

    // Entry adjustments: branch source offset and event-only upper byte.
    localparam logic [ADDR_W-1:0] COF_BRANCH_OFFSET = 16'h0002;
    localparam logic [7:0] EVENT_HIGH_BYTE = 8'h00;
    localparam logic [COUNT_W-1:0] STORED_FULL = 4'h8;

    // Run sequencer states.
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_WAIT,
        RUN_CAPTURE,
        RUN_END
    } run_state_t;

endpackage

// [rtl/capture_fifo.sv]
/*
  Shift-register history buffer with valid/ready on both sides.
  Assumes one clock; the head word and the valid flag are flip-flops.
*/
module capture_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic flush,
    input wire logic overwrite,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] count;
        logic notEmpty;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic full;
    logic pop;
    logic push;
    logic drop;
    logic [CW-1:0] level;

    // Entry 0 is always the oldest word, so the drain side reads a flop.
    // In overwrite mode a full buffer still accepts, losing its oldest word.
    always_comb begin
        next_s = s;
        full = (s.count == CW'(DEPTH));
        inReady = !full || overwrite;
        pop = s.notEmpty && outReady;
        push = inValid && inReady;
        drop = push && full && !pop; // RULE28
        level = s.count;
        if (pop || drop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_s.mem[i] = s.mem[i+1];
            end
            level = s.count - CW'(1);
        end
        if (push) begin
            next_s.mem[level] = inData;
            level = level + CW'(1);
        end
        next_s.count = level;
        next_s.notEmpty = (level != '0);
        if (flush) begin
            next_s.count = '0;
            next_s.notEmpty = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign outValid = s.notEmpty;
    assign outData = s.mem[0];

endmodule

// [rtl/trigger_mode_eval.sv]
/*
  Combinational trigger-mode evaluator: turns comparator results into flag
  sets, a trigger and a breakpoint hit. Assumes the comparators deliver per
  mode the bound condition for A and B (range modes) or a plain match.
*/
module trigger_mode_eval (
    // Configuration
    input wire logic [trace_trigger_pkg::MODE_W-1:0] mode,
    input wire logic opcodeQualify,
    input wire logic breakTag,
    input wire logic endRun,
    input wire logic aSeen,
    // Comparator results
    input wire logic matchA,
    input wire logic matchB,
    input wire logic opcodeA,
    input wire logic opcodeB,
    // Results
    output logic setA,
    output logic setB,
    output logic trigger,
    output logic breakHit,
    output logic eventOnly
);
    import trace_trigger_pkg::*;

    logic effA;
    logic effB;
    logic fullMode;

    // Opcode qualification applies except in the event-only modes.
    always_comb begin
        eventOnly = (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
        fullMode = (mode == MODE_A_AND_B) || (mode == MODE_A_AND_NOT_B);
        effA = (opcodeQualify && !eventOnly) ? opcodeA : matchA; // RULE24
        effB = (opcodeQualify && !eventOnly) ? opcodeB : matchB; // RULE24
        setA = 1'b0;
        setB = 1'b0;
        trigger = 1'b0;
        case (mode)
            MODE_A_ONLY: begin
                setA = effA; // RULE3
                trigger = effA;
            end
            MODE_A_OR_B, MODE_OUTSIDE: begin
                setA = effA; // RULE4 RULE12
                setB = effB;
                trigger = effA || effB;
            end
            MODE_A_THEN_B, MODE_A_THEN_EVENT_B: begin
                setA = effA; // RULE5 RULE7
                setB = effB && aSeen;
                trigger = setB;
            end
            MODE_EVENT_B: begin
                setB = effB; // RULE6
                trigger = effB;
            end
            MODE_A_AND_B, MODE_INSIDE: begin
                setA = effA && effB; // RULE8 RULE11
                setB = setA;
                trigger = setA;
            end
            MODE_A_AND_NOT_B: begin
                setA = effA && !effB; // RULE9
                setB = setA;
                trigger = setA;
            end
            default: begin
                trigger = 1'b0;
            end
        endcase
        // Tagged breaks in end runs of full modes look at comparator A only.
        breakHit = (fullMode && breakTag && endRun) ? effA : trigger; // RULE10
    end

endmodule

// [rtl/trace_trigger_capture.sv]
/*
  Trigger and capture sequencer of the on-chip trace unit. Holds the match
  flags, the armed state and the run sequencer, forms change-of-flow or event
  entries and feeds the eight-word history buffer.
  Assumes all inputs come from logic on ref_clk (core bus, comparators and
  the host's control bits), so none is synchronised.

  // Summary of operation
  // RULE1: Arming clears the A, B and C flags.
  // RULE2: Store flow addresses, or B-match data in event modes.
  // RULE3: A-only mode sets A flag on match.
  // RULE4: A-or-B sets whichever flags matched.
  // RULE5: A-then-B ignores B until A matched.
  // RULE6: Event-only-B sets B flag; always a begin run.
  // RULE7: A-then-event-B: B after A; always begin run.
  // RULE8: A-and-B sets both only on joint match.
  // RULE9: A-and-not-B sets both when A and no B.
  // RULE10: Full modes, tagged end runs: break on A only.
  // RULE11: Inside range sets both when both bounds hold.
  // RULE12: Outside range sets the flag of the met bound.
  // RULE13: End run fills until trigger; optional force break.
  // RULE14: Qualified end run stops at opcode; tag break.
  // RULE15: Begin run starts at trigger; force break when full.
  // RULE16: Host ignores tag when breaks off; qualify matches tag.
  // RULE17: Host avoids tagged breaks in begin runs.
  // RULE18: Eight 16-bit words; event entries upper byte zero.
  // RULE19: Indirect flow change stores current address.
  // RULE20: Taken branch stores previous address minus two.
  // RULE21: Begin run stores nothing before trigger, then eight.
  // RULE22: End runs never event-only; trigger disarms, stops storing.
  // RULE23: Trigger on flow change still stores that entry.
  // RULE24: Opcode qualification waits for executed opcode.
  // RULE25: A-only is code zero, A-or-B code one.
  // RULE26: Armed needs enable and arm; either clear disarms.
  // RULE27: Nine modes encoded zero to eight.
  // RULE28: End runs keep the eight newest entries.
*/
module trace_trigger_capture (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Host control bits
    input wire logic traceUnitEnable,
    input wire logic armSet,
    input wire logic armClear,
    input wire logic beginSelect,
    input wire logic opcodeQualifySelect,
    input wire logic coreBreakEnable,
    input wire logic breakTagType,
    input wire logic [trace_trigger_pkg::MODE_W-1:0] triggerMode,
    // Comparator results
    input wire logic cmpMatchA,
    input wire logic cmpMatchB,
    input wire logic cmpMatchC,
    input wire logic cmpOpcodeA,
    input wire logic cmpOpcodeB,
    // Core bus
    input wire logic [trace_trigger_pkg::ADDR_W-1:0] coreAddr,
    input wire logic [trace_trigger_pkg::DATA_W-1:0] coreData,
    input wire logic [1:0] coreCof,
    // Status
    output logic matchAFlag,
    output logic matchBFlag,
    output logic matchCFlag,
    output logic captureArmedFlag,
    // Break requests to the core
    output logic forceBreakReq,
    output logic tagBreakReq,
    // History buffer drain
    output logic bufValid,
    output logic [trace_trigger_pkg::WORD_W-1:0] bufData,
    input wire logic bufReady
);
    import trace_trigger_pkg::*;

    typedef struct packed {
        run_state_t runState;
        logic armBit;
        logic armedFlag;
        logic flagA;
        logic flagB;
        logic flagC;
        logic aSeen;
        logic runEvent;
        logic runEnd;
        logic [COUNT_W-1:0] storedCount;
        logic pendValid;
        logic [WORD_W-1:0] pendData;
        logic [ADDR_W-1:0] prevAddr;
        logic forceBrk;
        logic tagBrk;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    logic setA;
    logic setB;
    logic trigger;
    logic breakHit;
    logic eventOnly;
    logic fifoReady;
    logic fifoFlush;
    logic canStore;
    logic storeHit;
    logic armStart;
    logic finish;
    logic [WORD_W-1:0] entry;

    // Mode decode; the run sequencer's aSeen feeds the A-then-B modes.
    trigger_mode_eval u_eval (
        .mode(triggerMode),
        .opcodeQualify(opcodeQualifySelect),
        .breakTag(breakTagType),
        .endRun(s.runState == RUN_END),
        .aSeen(s.aSeen),
        .matchA(cmpMatchA),
        .matchB(cmpMatchB),
        .opcodeA(cmpOpcodeA),
        .opcodeB(cmpOpcodeB),
        .setA(setA),
        .setB(setB),
        .trigger(trigger),
        .breakHit(breakHit),
        .eventOnly(eventOnly)
    );

    // History buffer; end runs overwrite the oldest word instead of stalling.
    // The run type outlives the trigger, so the trigger's own entry still displaces.
    capture_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .resetn(resetn),
        .flush(fifoFlush),
        .overwrite(s.runEnd), // RULE28
        .inValid(s.pendValid),
        .inData(s.pendData),
        .inReady(fifoReady),
        .outValid(bufValid),
        .outData(bufData),
        .outReady(bufReady)
    );

    // Whole next-state function. A word waiting in the pending stage blocks
    // a new capture, so a stalled drain loses entries rather than corrupting.
    always_comb begin
        next_s = s;
        next_s.forceBrk = 1'b0;
        next_s.tagBrk = 1'b0;
        next_s.prevAddr = coreAddr;
        fifoFlush = 1'b0;
        storeHit = 1'b0;
        finish = 1'b0;
        canStore = !s.pendValid || fifoReady;
        armStart = (armSet || s.armBit) && traceUnitEnable && !s.armedFlag && !armClear
            && s.runState == RUN_IDLE;
        // Branch source is rebuilt from last cycle's address.
        if (coreCof[1]) begin
            entry = coreAddr; // RULE19
        end else begin
            entry = s.prevAddr - COF_BRANCH_OFFSET; // RULE20
        end
        if (s.runEvent) begin
            entry = {EVENT_HIGH_BYTE, coreData}; // RULE2 RULE18
        end
        if (s.pendValid && fifoReady) begin
            next_s.pendValid = 1'b0;
        end
        if (armClear) begin
            next_s.armBit = 1'b0; // RULE26
        end else if (armSet) begin
            next_s.armBit = 1'b1;
        end
        if (armStart) begin
            // New run: clean flags and buffer, fix the run type.
            next_s.flagA = 1'b0; // RULE1
            next_s.flagB = 1'b0;
            next_s.flagC = 1'b0;
            next_s.aSeen = 1'b0;
            next_s.storedCount = '0;
            next_s.pendValid = 1'b0;
            next_s.runEvent = eventOnly;
            next_s.runEnd = !(beginSelect || eventOnly);
            fifoFlush = 1'b1;
            if (beginSelect || eventOnly) begin
                next_s.runState = RUN_WAIT; // RULE6 RULE7 RULE22
            end else begin
                next_s.runState = RUN_END;
            end
        end else if (!(traceUnitEnable && next_s.armBit)) begin
            // The new arm bit is used so a clear in mid-run leaves the sequencer idle.
            next_s.runState = RUN_IDLE; // RULE26
        end else begin
            // Flags set while running; C is a plain breakpoint comparator.
            next_s.flagA = s.flagA || setA;
            next_s.flagB = s.flagB || setB;
            next_s.flagC = s.flagC || cmpMatchC;
            next_s.aSeen = s.aSeen || setA;
            unique case (s.runState)
                RUN_IDLE: begin
                    storeHit = 1'b0;
                end
                RUN_WAIT: begin
                    // Nothing is stored until the trigger cycle itself.
                    if (trigger) begin
                        next_s.runState = RUN_CAPTURE; // RULE21 RULE15
                        storeHit = s.runEvent ? setB : (coreCof != 2'b00);
                    end
                end
                RUN_CAPTURE: begin
                    storeHit = s.runEvent ? setB : (coreCof != 2'b00); // RULE2
                end
                RUN_END: begin
                    // The triggering flow change is still written.
                    storeHit = (coreCof != 2'b00); // RULE23
                    if (trigger) begin
                        finish = 1'b1; // RULE22
                    end
                    if (breakHit && coreBreakEnable) begin
                        next_s.forceBrk = !breakTagType; // RULE13
                        next_s.tagBrk = breakTagType; // RULE14
                    end
                end
            endcase
            if (storeHit && canStore) begin
                next_s.pendValid = 1'b1;
                next_s.pendData = entry;
                if (s.storedCount != STORED_FULL) begin
                    next_s.storedCount = s.storedCount + COUNT_W'(1);
                end
                if (s.runState != RUN_END && s.storedCount == STORED_FULL - COUNT_W'(1)) begin
                    finish = 1'b1; // RULE21
                    next_s.forceBrk = coreBreakEnable && !breakTagType; // RULE15
                end
            end
            if (finish) begin
                next_s.armBit = 1'b0;
                next_s.runState = RUN_IDLE;
            end
        end
        next_s.armedFlag = next_s.armBit && traceUnitEnable; // RULE26
    end

    // State register; every control bit starts disarmed and clear.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign matchAFlag = s.flagA;
    assign matchBFlag = s.flagB;
    assign matchCFlag = s.flagC;
    assign captureArmedFlag = s.armedFlag;
    assign forceBreakReq = s.forceBrk;
    assign tagBreakReq = s.tagBrk;

    // Checks on the sequencer, kept beside the logic they guard.
    property p_arm_clears;
        @(posedge ref_clk) disable iff (!resetn)
        armStart |=> !matchAFlag && !matchBFlag && !matchCFlag;
    endproperty
    a_arm_clears: assert property (p_arm_clears) else $error("flags survive arming"); // RULE1

    property p_event_high;
        @(posedge ref_clk) disable iff (!resetn)
        s.pendValid && s.runEvent |-> s.pendData[15:8] == EVENT_HIGH_BYTE;
    endproperty
    a_event_high: assert property (p_event_high) else $error("event entry upper byte set"); // RULE18

    property p_branch_src;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_END && !s.runEvent && coreCof == 2'b01 && canStore && s.armBit
            && traceUnitEnable && !armClear
            |=> s.pendValid && s.pendData == $past(s.prevAddr) - COF_BRANCH_OFFSET;
    endproperty
    a_branch_src: assert property (p_branch_src) else $error("branch source wrong"); // RULE20

    property p_indirect_dst;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_END && !s.runEvent && coreCof[1] && canStore && s.armBit
            && traceUnitEnable && !armClear
            |=> s.pendValid && s.pendData == $past(coreAddr);
    endproperty
    a_indirect_dst: assert property (p_indirect_dst) else $error("destination not stored"); // RULE19

    property p_no_pre_store;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_WAIT && !trigger && !s.pendValid |=> !s.pendValid;
    endproperty
    a_no_pre_store: assert property (p_no_pre_store) else $error("stored before trigger"); // RULE21

    property p_end_disarm;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_END && trigger && traceUnitEnable && s.armBit
            |=> !captureArmedFlag && s.runState == RUN_IDLE;
    endproperty
    a_end_disarm: assert property (p_end_disarm) else $error("end trigger left armed"); // RULE22

    property p_and_lone;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_END && triggerMode == MODE_A_AND_B && !opcodeQualifySelect
            && (cmpMatchA != cmpMatchB) && !s.flagA && !s.flagB && !armStart
            |=> !matchAFlag && !matchBFlag;
    endproperty
    a_and_lone: assert property (p_and_lone) else $error("lone match set a flag"); // RULE8

    property p_a_only;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState != RUN_IDLE && triggerMode == MODE_A_ONLY && !opcodeQualifySelect
            && cmpMatchA && traceUnitEnable && s.armBit && !armStart && !armClear
            |=> matchAFlag;
    endproperty
    a_a_only: assert property (p_a_only) else $error("A flag not set"); // RULE3

    property p_begin_full;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_CAPTURE && storeHit && canStore && s.storedCount == 4'h7
            && coreBreakEnable && !breakTagType && traceUnitEnable && s.armBit
            |=> forceBreakReq && !captureArmedFlag;
    endproperty
    a_begin_full: assert property (p_begin_full) else $error("no break when full"); // RULE15

    property p_disable;
        @(posedge ref_clk) disable iff (!resetn)
        !traceUnitEnable |=> !captureArmedFlag;
    endproperty
    a_disable: assert property (p_disable) else $error("armed while disabled"); // RULE26

    property p_end_force;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_END && trigger && coreBreakEnable && !breakTagType
            && traceUnitEnable && s.armBit && !armStart && !armClear |=> forceBreakReq;
    endproperty
    a_end_force: assert property (p_end_force) else $error("no force break"); // RULE13

    property p_cov_begin_done;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_CAPTURE ##1 s.runState == RUN_IDLE;
    endproperty
    c_cov_begin_done: cover property (p_cov_begin_done);

    property p_cov_end_tag;
        @(posedge ref_clk) disable iff (!resetn)
        s.runState == RUN_END ##1 tagBreakReq;
    endproperty
    c_cov_end_tag: cover property (p_cov_end_tag);

    property p_cov_event;
        @(posedge ref_clk) disable iff (!resetn)
        s.runEvent && s.pendValid;
    endproperty
    c_cov_event: cover property (p_cov_event);

endmodule

// [dv/buf_drain_model.sv]
/*
  Debug-host model that drains the history buffer and keeps every word read.
  Assumes the ref_clk domain; the bench raises stall to hold off reads.
*/
module buf_drain_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bench control
    input wire logic stall,
    // Buffer drain
    input wire logic bufValid,
    input wire logic [trace_trigger_pkg::WORD_W-1:0] bufData,
    output logic bufReady
);
    timeunit 1ns;
    timeprecision 1ps;
    import trace_trigger_pkg::*;
    logic [WORD_W-1:0] q[$];

    // Reads stop while stalled, so the buffer can be filled until it refuses.
    assign bufReady = !stall;

    // Words are kept in read order for the bench to compare.
    always @(posedge ref_clk) begin
        if (resetn && bufValid === 1'b1 && bufReady) begin
            q.push_back(bufData);
        end
    end
endmodule

// [dv/tb_trace_trigger_capture.sv]
/*
  Self-checking bench for the trace trigger and capture block.
  Assumes the drain model on the buffer side; inputs change at falling edges.
*/
module tb_trace_trigger_capture;
    timeunit 1ns;
    timeprecision 1ps;
    import trace_trigger_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, traceUnitEnable = 1'b1, stall = 1'b0;
    logic armSet = 1'b0, armClear = 1'b0, beginSelect = 1'b0, opcodeQualifySelect = 1'b0;
    logic coreBreakEnable = 1'b0, breakTagType = 1'b0, cmpOpcodeA = 1'b0, cmpOpcodeB = 1'b0;
    logic cmpMatchA = 1'b0, cmpMatchB = 1'b0, cmpMatchC = 1'b0;
    logic [MODE_W-1:0] triggerMode = MODE_A_ONLY;
    logic [ADDR_W-1:0] coreAddr = 16'h0000;
    logic [DATA_W-1:0] coreData = 8'h00;
    logic [1:0] coreCof = 2'h0;
    logic matchAFlag, matchBFlag, matchCFlag, captureArmedFlag, forceBreakReq, tagBreakReq;
    logic bufValid, bufReady;
    logic [WORD_W-1:0] bufData;
    int errorCnt = 0, cmpCount = 0, cycles = 0, frcCnt = 0;

    trace_trigger_capture dut (.ref_clk, .resetn, .traceUnitEnable, .armSet, .armClear,
        .beginSelect, .opcodeQualifySelect, .coreBreakEnable, .breakTagType, .triggerMode,
        .cmpMatchA, .cmpMatchB, .cmpMatchC, .cmpOpcodeA, .cmpOpcodeB, .coreAddr, .coreData,
        .coreCof, .matchAFlag, .matchBFlag, .matchCFlag, .captureArmedFlag, .forceBreakReq,
        .tagBreakReq, .bufValid, .bufData, .bufReady);
    buf_drain_model drain (.ref_clk, .resetn, .stall, .bufValid, .bufData, .bufReady);

    // Core bus clock at 100 MHz.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Force pulses are counted here; the ceiling cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles++;
        if (forceBreakReq === 1'b1) frcCnt++;
        if (cycles == 3000) begin
            errorCnt++;
            finishTest();
        end
    end

    task automatic finishTest;
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Disarm first, since a new run may only start from idle.
    task automatic arm(input logic [3:0] m, input logic beg, input logic [2:0] cfg);
        @(negedge ref_clk);
        triggerMode = m;
        beginSelect = beg;
        {opcodeQualifySelect, coreBreakEnable, breakTagType} = cfg;
        armClear = 1'b1;
        cyc(1);
        armClear = 1'b0;
        armSet = 1'b1;
        cyc(1);
        armSet = 1'b0;
        drain.q.delete();
        chk("armed", 1, captureArmedFlag);
        chk("flags at arm", 0, {matchAFlag, matchBFlag, matchCFlag});
    endtask

    // One comparator cycle, then flags, armed, force and tag are judged.
    task automatic hit(input logic [3:0] m, input logic [2:0] cfg, input logic [2:0] in,
            input logic [4:0] ex);
        arm(m, 1'b0, cfg);
        {cmpMatchA, cmpMatchB, cmpOpcodeA} = in;
        cyc(1);
        {cmpMatchA, cmpMatchB, cmpOpcodeA} = 3'h0;
        chk("flags armed breaks", ex,
            {matchAFlag, matchBFlag, captureArmedFlag, forceBreakReq, tagBreakReq});
    endtask

    // End run with a stalled reader: eleven entries, the newest eight survive.
    task automatic flow_end;
        arm(MODE_A_ONLY, 1'b0, 3'b010);
        stall = 1'b1;
        cmpMatchC = 1'b1;
        for (int i = 0; i < 9; i++) begin
            coreAddr = 16'h1200 + 16'(2 * i);
            coreCof = 2'h2;
            cyc(1);
            cmpMatchC = 1'b0;
        end
        coreAddr = 16'h2000;
        coreCof = 2'h0;
        cyc(1);
        coreAddr = 16'h2100;
        coreCof = 2'h1;
        cyc(1);
        coreAddr = 16'h3456;
        coreCof = 2'h2;
        cmpMatchA = 1'b1;
        cyc(1);
        cmpMatchA = 1'b0;
        coreAddr = 16'h4000;
        chk("force", 1, forceBreakReq);
        chk("armed", 0, captureArmedFlag);
        chk("flag C", 1, matchCFlag);
        cyc(1);
        coreCof = 2'h0;
        chk("force", 0, forceBreakReq);
        stall = 1'b0;
        cyc(14);
        chk("end count", 8, drain.q.size());
        for (int i = 0; i < 8; i++) begin
            chk("end word", i < 6 ? 16'h1206 + 16'(2 * i) : (i == 6 ? 16'h1ffe : 16'h3456),
                drain.q[i]);
        end
    endtask

    // Event run with a stalled reader: nine B matches, exactly eight kept.
    task automatic event_run(input logic [3:0] m);
        int frc;
        logic thenA;
        thenA = (m == MODE_A_THEN_EVENT_B);
        arm(m, 1'b0, 3'b010);
        frc = frcCnt;
        stall = 1'b1;
        coreAddr = 16'h5555;
        coreCof = 2'h2;
        cmpMatchA = thenA;
        cyc(1);
        coreCof = 2'h0;
        cmpMatchA = 1'b0;
        for (int i = 0; i < 9; i++) begin
            cmpMatchB = 1'b1;
            coreData = 8'h10 + 8'(i);
            cyc(1);
        end
        cmpMatchB = 1'b0;
        cyc(3);
        chk("event armed", 0, captureArmedFlag);
        chk("event force", 1, 16'(frcCnt - frc));
        chk("event flags", {thenA, 1'b1}, {matchAFlag, matchBFlag});
        stall = 1'b0;
        cyc(14);
        chk("event count", 8, drain.q.size());
        for (int i = 0; i < 8; i++) begin
            chk("event word", {8'h00, 8'h10 + 8'(i)}, drain.q[i]);
        end
    endtask

    task automatic disable_run;
        arm(MODE_A_ONLY, 1'b0, 3'b000);
        traceUnitEnable = 1'b0;
        cyc(1);
        traceUnitEnable = 1'b1;
        chk("armed after disable", 0, captureArmedFlag);
    endtask

    // Main sequence, after reset held for four cycles.
    initial begin
        cyc(4);
        resetn = 1'b1;
        flow_end();
        hit(MODE_A_ONLY, 3'b000, 3'b100, 5'b10000);
        hit(MODE_A_OR_B, 3'b000, 3'b010, 5'b01000);
        hit(MODE_A_THEN_B, 3'b000, 3'b010, 5'b00100);
        hit(MODE_A_AND_B, 3'b000, 3'b100, 5'b00100);
        hit(MODE_A_AND_B, 3'b000, 3'b110, 5'b11000);
        hit(MODE_A_AND_NOT_B, 3'b000, 3'b100, 5'b11000);
        hit(MODE_INSIDE, 3'b000, 3'b100, 5'b00100);
        hit(MODE_INSIDE, 3'b000, 3'b110, 5'b11000);
        hit(MODE_OUTSIDE, 3'b000, 3'b010, 5'b01000);
        hit(MODE_A_AND_B, 3'b111, 3'b101, 5'b00101);
        hit(MODE_A_ONLY, 3'b111, 3'b100, 5'b00100);
        hit(MODE_A_ONLY, 3'b111, 3'b001, 5'b10001);
        hit(MODE_A_ONLY, 3'b010, 3'b100, 5'b10010);
        event_run(MODE_EVENT_B);
        event_run(MODE_A_THEN_EVENT_B);
        disable_run();
        finishTest();
    end
endmodule
